/* design/sac_top.sv */
// converter controller: APB registers, channel mux over port pins, prescaler
// assumes an APB master on clk; port pins arrive asynchronously
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module sac_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    input wire logic cmp_high,
    output logic [7:0] dac_code,
    output logic sample_enable,
    output logic analog_power,
    output logic [4:0] mux_channel,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic conv_irq,
    output logic wake_request
);
    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic setup;
    logic access;
    logic [9:0] idx;
    logic mapped;
    logic wr_ctrl;
    logic wr_clk;
    logic wr_data;
    logic wr_dir;
    logic rd_result;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign idx = paddr[11:2];
    assign mapped = (idx == sac_pkg::IDX_CTRL) || (idx == sac_pkg::IDX_RESULT) ||
                    (idx == sac_pkg::IDX_CLKSEL) || (idx == sac_pkg::IDX_PORT_DATA) ||
                    (idx == sac_pkg::IDX_PORT_DIR);
    assign wr_ctrl = access & pwrite & (idx == sac_pkg::IDX_CTRL);
    assign wr_clk = access & pwrite & (idx == sac_pkg::IDX_CLKSEL);
    assign wr_data = access & pwrite & (idx == sac_pkg::IDX_PORT_DATA);
    assign wr_dir = access & pwrite & (idx == sac_pkg::IDX_PORT_DIR);
    assign rd_result = access & ~pwrite & (idx == sac_pkg::IDX_RESULT);
    // zero wait states
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic irq_en;
    logic repeat_conversion;
    logic [4:0] channel_select;
    logic [2:0] clock_divider_select;
    logic conv_done_flag;
    logic [7:0] result;
    logic conv_off;
    sac_seq_if sq ();

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_IRQ_BIT];
            repeat_conversion <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_REP_BIT];
            channel_select <= sac_pkg::CTRL_RESET[4:0];
        end else if (wr_ctrl) begin
            irq_en <= pwdata[sac_pkg::CTRL_IRQ_BIT];
            repeat_conversion <= pwdata[sac_pkg::CTRL_REP_BIT];
            channel_select <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clock_divider_select <= sac_pkg::CLKSEL_RESET;
        end else if (wr_clk) begin
            clock_divider_select <= pwdata[sac_pkg::CLK_DIV_LSB +: 3];
        end
    end

    assign conv_off = (channel_select == sac_pkg::CH_OFF);
    assign mux_channel = channel_select;
    assign analog_power = ~conv_off & ~stop_mode;

    // ****************************************************************
    // converter clock prescaler
    // ****************************************************************
    logic [3:0] div_cnt;
    logic [3:0] div_limit;

    // limit is ratio minus one: 0, 1, 3, 7, or 15
    assign div_limit = clock_divider_select[2] ? 4'hF :
                       (4'h1 << clock_divider_select[1:0]) - 4'h1;
    assign sq.tick = (div_cnt >= div_limit) & ~stop_mode;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 4'h0;
        end else if (stop_mode || sq.tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // ****************************************************************
    // start, abort and low-power handling
    // ****************************************************************
    logic start_pending;

    // a control write restarts the engine unless it selects the off channel; the old result is not trusted
    assign sq.abort = wr_ctrl | stop_mode | conv_off;
    assign sq.start = (start_pending | repeat_conversion) & ~conv_off;
    // comparator is a latch strobed by clk, so no synchroniser here
    assign sq.cmp_high = cmp_high;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_pending <= 1'b0;
        end else if (wr_ctrl) begin
            start_pending <= (pwdata[4:0] != sac_pkg::CH_OFF);
        end else if (stop_mode) begin
            // keep the request so the conversion runs again after stop
            start_pending <= start_pending | sq.busy;
        end else if (sq.started) begin
            start_pending <= 1'b0;
        end
    end

    sac_seq u_seq (
        .clk(clk),
        .reset(reset),
        .sq(sq)
    );

    assign dac_code = sq.trial;
    assign sample_enable = sq.sampling;

    // ****************************************************************
    // result, flag and interrupt
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result <= 8'h00;
        end else if (sq.done) begin
            result <= sq.result;
        end
    end

    // set wins over the clearing read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_done_flag <= 1'b0;
        end else if (sq.done && !irq_en) begin
            conv_done_flag <= 1'b1;
        end else if (rd_result) begin
            conv_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_irq <= 1'b0;
        end else if (sq.done && irq_en) begin
            conv_irq <= 1'b1;
        end else if (rd_result || wr_ctrl) begin
            conv_irq <= 1'b0;
        end
    end

    // wait mode leaves the engine running
    assign wake_request = conv_irq & wait_mode;

    // ****************************************************************
    // port pins shared with the channels
    // ****************************************************************
    logic [5:0] port_data;
    logic [5:0] port_dir;
    logic [5:0] pin_sel;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] port_read;

    assign pin_sel = (channel_select[4:2] == 3'h0) ? sac_pkg::CH_PIN_MASK[channel_select[1:0]] : 6'h00;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_data <= 6'h00;
        end else if (wr_data) begin
            port_data <= (pwdata[5:0] & ~pin_sel) | (port_data & pin_sel);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_dir <= 6'h00;
        end else if (wr_dir) begin
            port_dir <= (pwdata[5:0] & ~pin_sel) | (port_dir & pin_sel);
        end
    end

    assign pin_out = port_data;
    assign pin_oe = port_dir & ~pin_sel;

    for (genvar i = 0; i < 6; i++) begin : g_pin
        // a converter pin never reads its analog level
        assign port_read[i] = port_dir[i] ? port_data[i] :
                              (pin_sel[i] ? 1'b0 : pin_sync[i]);
    end

    // ****************************************************************
    // read data, captured in the setup cycle
    // ****************************************************************
    logic [7:0] read_byte;

    always_comb begin
        read_byte = 8'h00;
        case (idx)
            sac_pkg::IDX_CTRL: begin
                read_byte = {conv_done_flag & ~irq_en, irq_en, repeat_conversion,
                             channel_select};
            end
            sac_pkg::IDX_RESULT: begin
                read_byte = result;
            end
            sac_pkg::IDX_CLKSEL: begin
                read_byte = {clock_divider_select, 5'h00};
            end
            sac_pkg::IDX_PORT_DATA: begin
                read_byte = {2'h0, port_read};
            end
            sac_pkg::IDX_PORT_DIR: begin
                read_byte = {2'h0, port_dir};
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= {24'h00_0000, read_byte};
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [3:0] tick_seen;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_seen <= 4'h0;
        end else if (sq.started) begin
            tick_seen <= {3'h0, sq.tick};
        end else if (sq.tick) begin
            tick_seen <= tick_seen + 4'h1;
        end
    end

    conv_len_a: assert property (@(posedge clk) disable iff (reset)
        sq.done |-> tick_seen == 4'hF)
        else $error("conversion did not take sixteen ticks");

    write_start_a: assert property (@(posedge clk) disable iff (reset || stop_mode)
        (wr_ctrl && pwdata[4:0] != sac_pkg::CH_OFF) |-> ##[1:17] sq.started)
        else $error("control write did not start a conversion");

    repeat_run_a: assert property (@(posedge clk) disable iff (reset || stop_mode)
        (sq.done && repeat_conversion && !conv_off && !wr_ctrl) |-> ##[1:17] sq.started)
        else $error("continuous mode did not restart");

    single_idle_a: assert property (@(posedge clk) disable iff (reset)
        (sq.done && !repeat_conversion) |=> !sq.busy)
        else $error("single mode kept converting");

    result_load_a: assert property (@(posedge clk) disable iff (reset)
        sq.done |=> result == $past(sq.result))
        else $error("result not loaded at end of conversion");

    flag_hold_a: assert property (@(posedge clk) disable iff (reset)
        (conv_done_flag && !rd_result) |=> conv_done_flag)
        else $error("done flag dropped without a result read");

    flag_set_a: assert property (@(posedge clk) disable iff (reset)
        (sq.done && !irq_en) |=> conv_done_flag && !conv_irq)
        else $error("done flag not set");

    irq_flag_a: assert property (@(posedge clk) disable iff (reset)
        (setup && !pwrite && idx == sac_pkg::IDX_CTRL && irq_en) |=> !prdata[7])
        else $error("done flag visible with interrupts on");

    irq_clear_a: assert property (@(posedge clk) disable iff (reset)
        ((rd_result || wr_ctrl) && !sq.done) |=> !conv_irq)
        else $error("interrupt not cleared");

    pin_keep_a: assert property (@(posedge clk) disable iff (reset)
        (wr_data || wr_dir) |=> ((port_data ^ $past(port_data)) & pin_sel) == 6'h00 &&
            ((port_dir ^ $past(port_dir)) & pin_sel) == 6'h00)
        else $error("write changed the converter pin");

    pin_float_a: assert property (@(posedge clk) disable iff (reset)
        (pin_oe & pin_sel) == 6'h00)
        else $error("converter pin driven");

    pin_read_a: assert property (@(posedge clk) disable iff (reset)
        (setup && !pwrite && idx == sac_pkg::IDX_PORT_DATA) |=>
            (prdata[5:0] & $past(pin_sel)) == $past(port_data & port_dir & pin_sel))
        else $error("converter pin read wrong");

    stop_abort_a: assert property (@(posedge clk) disable iff (reset)
        stop_mode |-> !sq.tick ##1 !sq.busy)
        else $error("engine ran in stop mode");

    power_off_a: assert property (@(posedge clk) disable iff (reset)
        conv_off |-> !analog_power ##1 !sq.busy)
        else $error("engine ran with channel off");

    irq_done_c: cover property (@(posedge clk) disable iff (reset)
        sq.done && irq_en);
    repeat_c: cover property (@(posedge clk) disable iff (reset)
        sq.done && repeat_conversion ##[1:300] sq.done);
    stop_c: cover property (@(posedge clk) disable iff (reset)
        sq.busy ##1 stop_mode);
    flag_read_c: cover property (@(posedge clk) disable iff (reset)
        conv_done_flag && rd_result);
endmodule : sac_top

/* design/sac_pkg.sv */
// constants shared by the converter controller and its sequencer
// assumes APB byte addressing, 32-bit data, registers at index*4
package sac_pkg;
    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_PORT_DATA = 10'h000;
    localparam logic [9:0] IDX_PORT_DIR = 10'h001;
    localparam logic [9:0] IDX_CTRL = 10'h03C;
    localparam logic [9:0] IDX_RESULT = 10'h03E;
    localparam logic [9:0] IDX_CLKSEL = 10'h03F;
    // control/status fields
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_IRQ_BIT = 6;
    localparam int CTRL_REP_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam logic [4:0] CH_OFF = 5'h1F;
    // clock select field
    localparam int CLK_DIV_LSB = 5;
    localparam logic [2:0] CLKSEL_RESET = 3'h0;
    // sequencer timing in converter clock ticks, and the first trial code
    localparam logic [3:0] SAMPLE_LAST = 4'h7;
    localparam logic [3:0] CONV_LAST = 4'hF;
    localparam logic [7:0] TRIAL_FIRST = 8'h80;
    // port pins shared with the four channels
    localparam logic [5:0] CH_PIN_MASK [4] = '{6'h01, 6'h02, 6'h10, 6'h20};
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_RESOLVE = 2'b10
    } sac_state_e;
endpackage : sac_pkg

/* design/sac_seq_if.sv */
// signals between the register front end and the sequencer
// assumes both ends run on the one bus clock
`timescale 1ns/1ps
interface sac_seq_if;
    logic tick;
    logic start;
    logic abort;
    logic cmp_high;
    logic started;
    logic done;
    logic busy;
    logic sampling;
    logic [7:0] trial;
    logic [7:0] result;
    modport ctrl (output tick, start, abort, cmp_high,
                  input started, done, busy, sampling, trial, result);
    modport seq (input tick, start, abort, cmp_high,
                 output started, done, busy, sampling, trial, result);
endinterface : sac_seq_if

/* design/sac_seq.sv */
// successive approximation sequencer, sixteen converter ticks per result
// assumes tick is a one-cycle enable and cmp_high is on clk
`timescale 1ns/1ps
module sac_seq (
    input wire logic clk,
    input wire logic reset,
    sac_seq_if.seq sq
);
    sac_pkg::sac_state_e state;
    logic [3:0] count;
    logic [7:0] mask;
    logic [7:0] kept;

    // clear the trial bit when the input is below the trial level
    assign kept = sq.cmp_high ? sq.trial : (sq.trial & ~mask);
    assign sq.busy = (state != sac_pkg::SAC_IDLE);
    assign sq.sampling = (state == sac_pkg::SAC_SAMPLE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= sac_pkg::SAC_IDLE;
            count <= 4'h0;
            mask <= 8'h00;
            sq.trial <= 8'h00;
            sq.result <= 8'h00;
            sq.started <= 1'b0;
            sq.done <= 1'b0;
        end else begin
            sq.started <= 1'b0;
            sq.done <= 1'b0;
            if (sq.abort) begin
                state <= sac_pkg::SAC_IDLE;
                count <= 4'h0;
            end else if (sq.tick) begin
                case (state)
                    sac_pkg::SAC_IDLE: begin
                        if (sq.start) begin
                            state <= sac_pkg::SAC_SAMPLE;
                            count <= 4'h1;
                            mask <= sac_pkg::TRIAL_FIRST;
                            sq.trial <= sac_pkg::TRIAL_FIRST;
                            sq.started <= 1'b1;
                        end
                    end
                    sac_pkg::SAC_SAMPLE: begin
                        count <= count + 4'h1;
                        if (count == sac_pkg::SAMPLE_LAST) begin
                            state <= sac_pkg::SAC_RESOLVE;
                        end
                    end
                    sac_pkg::SAC_RESOLVE: begin
                        // msb first, one bit per tick
                        count <= count + 4'h1;
                        mask <= mask >> 1;
                        sq.trial <= kept | (mask >> 1);
                        if (count == sac_pkg::CONV_LAST) begin
                            state <= sac_pkg::SAC_IDLE;
                            sq.result <= kept;
                            sq.done <= 1'b1;
                        end
                    end
                    default: begin
                        state <= sac_pkg::SAC_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : sac_seq

/* dv/sac_analog_model.sv */
// far side of the converter: four channel levels, comparator, port pins
// assumes dac_code and mux_channel are driven by the controller on clk
`timescale 1ns/1ps
module sac_analog_model (
    input wire logic [31:0] levels,
    input wire logic [4:0] mux_channel,
    input wire logic [7:0] dac_code,
    input wire logic analog_power,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output logic cmp_high,
    output logic [5:0] pin_in
);
    // unpowered or unused channel keeps the comparator low
    always_comb begin
        if (analog_power && mux_channel < 5'h04) begin
            cmp_high = levels[8 * mux_channel[1:0] +: 8] >= dac_code;
        end else begin
            cmp_high = 1'b0;
        end
    end
    // released pins sit at the pull-up level
    assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule : sac_analog_model

/* dv/sac_top_test.sv */
// self-checking bench for sac_top over APB
// assumes the analog model in sac_analog_model.sv stands at the far side
`timescale 1ns/1ps
module sac_top_test;
    localparam logic [11:0] A_DATA = {sac_pkg::IDX_PORT_DATA, 2'b00};
    localparam logic [11:0] A_DIR = {sac_pkg::IDX_PORT_DIR, 2'b00};
    localparam logic [11:0] A_CTRL = {sac_pkg::IDX_CTRL, 2'b00};
    localparam logic [11:0] A_RES = {sac_pkg::IDX_RESULT, 2'b00};
    localparam logic [11:0] A_CLK = {sac_pkg::IDX_CLKSEL, 2'b00};
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, e, cmp_high, sample_enable, analog_power, conv_irq, wake_request;
    logic [5:0] pin_in, pin_out, pin_oe;
    logic [7:0] dac_code;
    logic [4:0] mux_channel;
    logic wait_mode = 0, stop_mode = 0;
    logic [31:0] levels = 32'h00FF3CA5;
    int n_errors = 0, checks = 0, cyc = 0, n, rt, k;
    int divs [6] = '{0, 1, 2, 3, 4, 7};

    always #50 clk = ~clk;

    sac_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_high(cmp_high),
        .dac_code(dac_code), .sample_enable(sample_enable), .analog_power(analog_power),
        .mux_channel(mux_channel), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .conv_irq(conv_irq), .wake_request(wake_request));
    sac_analog_model far (.levels(levels), .mux_channel(mux_channel), .dac_code(dac_code),
        .analog_power(analog_power), .pin_out(pin_out), .pin_oe(pin_oe),
        .cmp_high(cmp_high), .pin_in(pin_in));

    // ****************
    // shared tasks
    // ****************
    task automatic results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // waits for the interrupt, counting bus cycles
    task automatic wirq;
        n = 0;
        while (conv_irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wirq

    // cycle ceiling well above the 1400 or so the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    // ****************
    // tests
    // ****************
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(0, A_CTRL, 0); chk(r, 32'h1F);
        apb(0, A_CLK, 0); chk(r, 32'h0);
        chk(analog_power, 1'b0);
        apb(1, A_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk(sample_enable, 1'b1);
        chk(dac_code, 8'h80);
        repeat (36) @(posedge clk);
        apb(0, A_CTRL, 0); chk(r, 32'h80);
        apb(0, A_RES, 0); chk(r, 32'hA5);
        apb(0, A_CTRL, 0); chk(r, 32'h00);
        @(posedge clk) wait_mode <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            apb(1, A_CTRL, 8'h40 | 8'(ch));
            wirq(); chk(32'(n >= 17 && n <= 18), 1);
            chk(wake_request, 1'b1);
            apb(0, A_CTRL, 0); chk(r, 32'h40 | 32'(ch));
            apb(0, A_RES, 0); chk(r, 32'(levels[8 * ch +: 8]));
            chk(conv_irq, 1'b0);
        end
        apb(1, A_CTRL, 8'h43);
        wirq();
        apb(1, A_CTRL, 8'h1F); chk(conv_irq, 1'b0);
        chk(analog_power, 1'b0);
        @(posedge clk) wait_mode <= 1'b0;
        foreach (divs[i]) begin
            k = divs[i];
            rt = (k > 3) ? 16 : (1 << k);
            apb(1, A_CLK, 8'(k << 5));
            apb(0, A_CLK, 0); chk(r, 32'(k << 5));
            apb(1, A_CTRL, 8'h40);
            wirq(); chk(32'(n >= 15 * rt + 2 && n <= 16 * rt + 2), 1);
            apb(0, A_RES, 0);
        end
        apb(1, A_CLK, 8'h00);
        apb(1, A_CTRL, 8'h20);
        repeat (20) @(posedge clk);
        levels[7:0] <= 8'h5A;
        repeat (60) @(posedge clk);
        apb(0, A_CTRL, 0); chk(r, 32'hA0);
        apb(0, A_RES, 0); chk(r, 32'h5A);
        apb(1, A_CTRL, 8'h00);
        repeat (40) @(posedge clk);
        apb(0, A_RES, 0); chk(r, 32'h5A);
        repeat (40) @(posedge clk);
        apb(0, A_CTRL, 0); chk(r, 32'h00);
        apb(1, A_CTRL, 8'h41);
        repeat (8) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk);
        chk(analog_power, 1'b0);
        repeat (60) @(posedge clk);
        chk(conv_irq, 1'b0);
        stop_mode <= 1'b0;
        wirq(); chk(32'(n <= 40), 1);
        apb(0, A_RES, 0); chk(r, 32'h3C);
        apb(1, A_CTRL, 8'h1F);
        apb(1, A_DIR, 8'h3F);
        apb(1, A_DATA, 8'h15);
        apb(1, A_CTRL, 8'h00); chk(pin_oe, 6'h3E);
        apb(0, A_DATA, 0); chk(r, 32'h15);
        apb(1, A_CTRL, 8'h1F);
        apb(1, A_DIR, 8'h3E);
        apb(1, A_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        apb(0, A_DATA, 0); chk(r, 32'h14);
        apb(1, A_DIR, 8'h3F);
        apb(0, A_DIR, 0); chk(r, 32'h3E);
        apb(1, A_DATA, 8'h2A); chk(pin_out, 6'h2B);
        apb(1, A_CTRL, 8'h1F);
        apb(1, A_DIR, 8'h3F); chk(pin_oe, 6'h3F);
        apb(0, 12'h080, 0); chk({r[30:0], e}, 32'h1);
        results();
    end
endmodule : sac_top_test
